// file: src/agc_pkg.sv
package agc_pkg;
    // register byte addresses: printed offsets are indexes, byte address = 4 * index
    localparam logic [3:0] IDX_Q_FULL_SCALE_TRIM = 4'hb;
    localparam logic [3:0] IDX_SAMPLE_PHASE_FINE = 4'he;
    localparam logic [3:0] IDX_SAMPLE_PHASE_COARSE = 4'hf;
    localparam logic [11:0] ADDR_Q_FULL_SCALE_TRIM = {2'h0, IDX_Q_FULL_SCALE_TRIM, 2'h0};
    localparam logic [11:0] ADDR_SAMPLE_PHASE_FINE = {2'h0, IDX_SAMPLE_PHASE_FINE, 2'h0};
    localparam logic [11:0] ADDR_SAMPLE_PHASE_COARSE = {2'h0, IDX_SAMPLE_PHASE_COARSE, 2'h0};
    // reset values of the whole words
    localparam logic [15:0] RST_Q_FULL_SCALE_TRIM = 16'h807f;
    localparam logic [15:0] RST_SAMPLE_PHASE_FINE = 16'h00ff;
    localparam logic [15:0] RST_SAMPLE_PHASE_COARSE = 16'h007f;
    // field positions
    localparam int GAIN_LSB = 7;
    localparam int GAIN_W = 9;
    localparam int FINE_LSB = 8;
    localparam int FINE_W = 8;
    localparam int POL_BIT = 15;
    localparam int COARSE_LSB = 10;
    localparam int COARSE_W = 5;
    localparam int INTER_LSB = 7;
    localparam int INTER_W = 3;
    // recommended gain window and nominal code
    localparam logic [8:0] GAIN_NOMINAL = 9'h100;
    localparam logic [8:0] GAIN_REC_MIN = 9'h0c0;
    localparam logic [8:0] GAIN_REC_MAX = 9'h1c0;
    // nominal step sizes in femtoseconds
    localparam int COARSE_STEP_FS = 65000;
    localparam int INTER_STEP_FS = 11000;
    localparam int MAX_COMBINED_FS = 2100000;

    typedef struct packed {
        logic [8:0] gain_trim;
        logic [7:0] fine_phase;
        logic clock_polarity_invert;
        logic [4:0] coarse_phase;
        logic [2:0] intermediate_phase_step;
    } agc_cfg_t;

    typedef struct packed {
        agc_cfg_t cfg;
        logic [15:0] gain_word;
        logic [15:0] fine_word;
        logic [15:0] coarse_word;
        logic pready;
        logic pslverr;
        logic gain_updated;
        logic gain_out_of_range;
        logic pad_violation;
        logic [11:0] coarse_delay_ps;
        logic gain_trim_active;
    } agc_state_t;
endpackage : agc_pkg

// file: src/agc_regs.sv
`timescale 1ns/100ps
module agc_regs #(
    parameter int ADDR_W = 12
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic extended_mode,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [8:0] gain_trim,
    output logic gain_trim_active,
    output logic gain_updated,
    output logic gain_out_of_range,
    output logic [7:0] fine_phase,
    output logic clock_polarity_invert,
    output logic [4:0] coarse_phase,
    output logic [2:0] intermediate_phase_step,
    output logic [11:0] coarse_delay_ps,
    output logic pad_violation
);
    agc_pkg::agc_state_t s_q;
    agc_pkg::agc_state_t s_d;
    logic acc;
    logic hit_gain;
    logic hit_fine;
    logic hit_coarse;
    logic full_wr;

    // refuse address widths that cannot hold the map or exceed the bus
    if (ADDR_W < 6 || ADDR_W > 32) begin : g_addr_w_check
        $error("agc_regs: ADDR_W outside 6..32");
    end

    // decode of the access phase
    assign acc = psel && penable && !s_q.pready;
    assign full_wr = pwrite && (pstrb == 4'hf);
    assign hit_gain = paddr == ADDR_W'(agc_pkg::ADDR_Q_FULL_SCALE_TRIM);
    assign hit_fine = paddr == ADDR_W'(agc_pkg::ADDR_SAMPLE_PHASE_FINE);
    assign hit_coarse = paddr == ADDR_W'(agc_pkg::ADDR_SAMPLE_PHASE_COARSE);

    // next state: one wait state, then answer
    always_comb begin
        s_d = s_q;
        s_d.pready = acc;
        s_d.pslverr = 1'b0;
        s_d.gain_updated = 1'b0;
        // full-scale word only acts in extended control mode
        s_d.gain_trim_active = extended_mode;
        if (acc) begin
            // reads and unmapped or partial accesses are refused
            if (!full_wr || !(hit_gain || hit_fine || hit_coarse)) begin
                s_d.pslverr = 1'b1;
            end else if (hit_gain) begin
                s_d.gain_word = pwdata[15:0];
                s_d.cfg.gain_trim = pwdata[agc_pkg::GAIN_LSB +: agc_pkg::GAIN_W];
                s_d.gain_updated = 1'b1;
                s_d.gain_out_of_range = (pwdata[agc_pkg::GAIN_LSB +: agc_pkg::GAIN_W] < agc_pkg::GAIN_REC_MIN)
                    || (pwdata[agc_pkg::GAIN_LSB +: agc_pkg::GAIN_W] > agc_pkg::GAIN_REC_MAX);
                s_d.pad_violation = s_q.pad_violation || (pwdata[6:0] != 7'h7f);
            end else if (hit_fine) begin
                s_d.fine_word = pwdata[15:0];
                s_d.cfg.fine_phase = pwdata[agc_pkg::FINE_LSB +: agc_pkg::FINE_W];
                s_d.pad_violation = s_q.pad_violation || (pwdata[7:0] != 8'hff);
            end else begin
                s_d.coarse_word = pwdata[15:0];
                s_d.cfg.clock_polarity_invert = pwdata[agc_pkg::POL_BIT];
                s_d.cfg.coarse_phase = pwdata[agc_pkg::COARSE_LSB +: agc_pkg::COARSE_W];
                s_d.cfg.intermediate_phase_step = pwdata[agc_pkg::INTER_LSB +: agc_pkg::INTER_W];
                s_d.pad_violation = s_q.pad_violation || (pwdata[6:0] != 7'h7f);
            end
        end
        // nominal combined coarse delay in ps, 31*65+7*11 = 2092 near 2.1 ns
        s_d.coarse_delay_ps = 12'(({7'h0, s_d.cfg.coarse_phase} * 12'(agc_pkg::COARSE_STEP_FS / 1000))
            + ({9'h0, s_d.cfg.intermediate_phase_step} * 12'(agc_pkg::INTER_STEP_FS / 1000)));
    end

    // state register with reset to power-on values
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_q.gain_word <= agc_pkg::RST_Q_FULL_SCALE_TRIM;
            s_q.fine_word <= agc_pkg::RST_SAMPLE_PHASE_FINE;
            s_q.coarse_word <= agc_pkg::RST_SAMPLE_PHASE_COARSE;
            s_q.cfg.gain_trim <= agc_pkg::RST_Q_FULL_SCALE_TRIM[agc_pkg::GAIN_LSB +: agc_pkg::GAIN_W];
            s_q.cfg.fine_phase <= agc_pkg::RST_SAMPLE_PHASE_FINE[agc_pkg::FINE_LSB +: agc_pkg::FINE_W];
            s_q.cfg.clock_polarity_invert <= agc_pkg::RST_SAMPLE_PHASE_COARSE[agc_pkg::POL_BIT];
            s_q.cfg.coarse_phase <= agc_pkg::RST_SAMPLE_PHASE_COARSE[agc_pkg::COARSE_LSB +: agc_pkg::COARSE_W];
            s_q.cfg.intermediate_phase_step <= agc_pkg::RST_SAMPLE_PHASE_COARSE[agc_pkg::INTER_LSB +: agc_pkg::INTER_W];
            s_q.pready <= 1'b0;
            s_q.pslverr <= 1'b0;
            s_q.gain_updated <= 1'b0;
            s_q.gain_out_of_range <= 1'b0;
            s_q.pad_violation <= 1'b0;
            s_q.coarse_delay_ps <= 12'h0;
            s_q.gain_trim_active <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops; write-only words read as zero
    assign prdata = 32'h0;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign gain_trim = s_q.cfg.gain_trim;
    assign gain_trim_active = s_q.gain_trim_active;
    assign gain_updated = s_q.gain_updated;
    assign gain_out_of_range = s_q.gain_out_of_range;
    assign fine_phase = s_q.cfg.fine_phase;
    assign clock_polarity_invert = s_q.cfg.clock_polarity_invert;
    assign coarse_phase = s_q.cfg.coarse_phase;
    assign intermediate_phase_step = s_q.cfg.intermediate_phase_step;
    assign coarse_delay_ps = s_q.coarse_delay_ps;
    assign pad_violation = s_q.pad_violation;

    // gain write shows up one cycle after the accepting edge
    gain_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (acc && full_wr && hit_gain) |=> (gain_trim == $past(pwdata[15:7]) && gain_updated))
        else $error("gain trim not loaded");
    gain_reset_a: assert property (@(posedge clk_sys)
        sys_rst |=> (gain_trim == 9'h100 && fine_phase == 8'h00))
        else $error("reset values wrong");
    fine_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (acc && full_wr && hit_fine) |=> (fine_phase == $past(pwdata[15:8])))
        else $error("fine phase not loaded");
    pol_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (acc && full_wr && hit_coarse) |=> (clock_polarity_invert == $past(pwdata[15])))
        else $error("polarity not loaded");
    coarse_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (acc && full_wr && hit_coarse) |=> (coarse_phase == $past(pwdata[14:10])
        && intermediate_phase_step == $past(pwdata[9:7])))
        else $error("coarse fields not loaded");
    delay_max_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        coarse_delay_ps <= 12'd2100)
        else $error("combined delay above 2.1 ns");
    hold_value_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !(acc && full_wr && hit_gain) |=> $stable(gain_trim))
        else $error("gain changed without write");
    answer_time_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (psel && penable && !pready) |=> pready ##1 !pready)
        else $error("apb answer not one cycle");

    // whole gain word kept as written
    word_store_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (acc && full_wr && hit_gain)
        |=> (s_q.gain_word == $past(pwdata[15:0])))
        else $error("gain word not stored");

    // top code of the trim range loads unchanged
    gain_max_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (acc && full_wr && hit_gain && pwdata[15:7] == 9'h1ff)
        |=> (gain_trim == 9'h1ff))
        else $error("maximum gain code lost");

    // bottom code of the trim range loads unchanged
    gain_min_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (acc && full_wr && hit_gain && pwdata[15:7] == 9'h000)
        |=> (gain_trim == 9'h000))
        else $error("minimum gain code lost");

    // flag follows the recommended window
    gain_window_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        gain_out_of_range
        == ((gain_trim < agc_pkg::GAIN_REC_MIN) || (gain_trim > agc_pkg::GAIN_REC_MAX)))
        else $error("gain window flag wrong");

    // fine phase clears on reset
    fine_reset_a: assert property (@(posedge clk_sys)
        sys_rst
        |=> (fine_phase == 8'h00))
        else $error("fine phase reset wrong");

    // polarity clears on reset
    pol_reset_a: assert property (@(posedge clk_sys)
        sys_rst
        |=> !clock_polarity_invert)
        else $error("polarity reset wrong");

    // coarse step clears on reset
    coarse_reset_a: assert property (@(posedge clk_sys)
        sys_rst
        |=> (coarse_phase == 5'h00))
        else $error("coarse phase reset wrong");

    // intermediate step clears on reset
    inter_reset_a: assert property (@(posedge clk_sys)
        sys_rst
        |=> (intermediate_phase_step == 3'h0))
        else $error("intermediate step reset wrong");

    // intermediate step loads from its own field
    inter_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (acc && full_wr && hit_coarse)
        |=> (intermediate_phase_step == $past(pwdata[9:7])))
        else $error("intermediate step not loaded");

    // delay figure matches the two fields
    delay_sum_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        coarse_delay_ps
        == (({7'h0, coarse_phase} * 12'd65) + ({9'h0, intermediate_phase_step} * 12'd11)))
        else $error("combined delay wrong");

    // fine phase holds between its writes
    fine_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !(acc && full_wr && hit_fine)
        |=> $stable(fine_phase))
        else $error("fine phase changed without write");

    // coarse word fields hold between writes
    coarse_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !(acc && full_wr && hit_coarse)
        |=> $stable({clock_polarity_invert, coarse_phase, intermediate_phase_step}))
        else $error("coarse word changed without write");

    // refused access answers with error and keeps gain trim and fine phase
    refuse_keep_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (acc && !(full_wr && (hit_gain || hit_fine || hit_coarse)))
        |=> (pready && pslverr && $stable(gain_trim) && $stable(fine_phase)))
        else $error("refused access not handled");

    // accepted write answers without error
    write_ack_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (acc && full_wr && (hit_gain || hit_fine || hit_coarse))
        |=> (pready && !pslverr))
        else $error("write not acknowledged");

    // ready is a single-cycle pulse
    ready_pulse_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pready
        |=> !pready)
        else $error("ready held too long");

    // error only qualifies a ready
    error_qual_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pslverr
        |-> pready)
        else $error("error without ready");

    // update pulse comes with a clean answer
    update_ack_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        gain_updated
        |-> (pready && !pslverr))
        else $error("update pulse without answer");

    // update pulse only after a gain write
    update_cause_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        gain_updated
        |-> $past(acc && full_wr && hit_gain))
        else $error("update pulse without gain write");

    // pad flag stays set until reset
    pad_sticky_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pad_violation
        |=> pad_violation)
        else $error("pad flag cleared");

    // bad fine pads raise the flag
    pad_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (acc && full_wr && hit_fine && pwdata[7:0] != 8'hff)
        |=> pad_violation)
        else $error("fine pad fault missed");

    // no answer without a selected transfer
    idle_quiet_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !psel
        |=> !pready)
        else $error("answer while idle");

    // active flag follows the control mode
    mode_follow_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !$past(sys_rst)
        |-> (gain_trim_active == $past(extended_mode)))
        else $error("mode flag wrong");

    // refused access never reports a gain update
    err_no_update_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pslverr
        |-> !gain_updated)
        else $error("update on refused access");
endmodule : agc_regs

// file: test/agc_regs_tb.sv
`timescale 1ns/100ps
module testbench;
    localparam logic [11:0] A_G = agc_pkg::ADDR_Q_FULL_SCALE_TRIM;
    localparam logic [11:0] A_F = agc_pkg::ADDR_SAMPLE_PHASE_FINE;
    localparam logic [11:0] A_C = agc_pkg::ADDR_SAMPLE_PHASE_COARSE;
    logic clk_sys, sys_rst, extended_mode, psel, penable, pwrite, pready, pslverr;
    logic gain_trim_active, gain_out_of_range, clock_polarity_invert, pad_violation, e_pad, gain_updated;
    logic upd_q [$];
    logic [11:0] paddr, coarse_delay_ps;
    logic [31:0] pwdata, prdata, seed;
    logic [3:0] pstrb;
    logic [8:0] gain_trim;
    logic [7:0] fine_phase;
    logic [4:0] coarse_phase;
    logic [2:0] intermediate_phase_step;
    logic [15:0] e_g, e_f, e_c, d;
    logic [11:0] ad;
    logic [40:0] exp_q [$];
    logic [40:0] obs;
    logic [8:0] gtab [7] = '{9'h000, 9'h0bf, 9'h0c0, 9'h100, 9'h1c0, 9'h1c1, 9'h1ff};
    int n_fail, total_checks;

    agc_regs dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .extended_mode(extended_mode), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .gain_trim(gain_trim), .gain_trim_active(gain_trim_active),
        .gain_updated(gain_updated), .gain_out_of_range(gain_out_of_range), .fine_phase(fine_phase),
        .clock_polarity_invert(clock_polarity_invert), .coarse_phase(coarse_phase),
        .intermediate_phase_step(intermediate_phase_step), .coarse_delay_ps(coarse_delay_ps),
        .pad_violation(pad_violation));

    // observed outputs in one word
    assign obs = {pslverr, gain_trim, fine_phase, clock_polarity_invert, coarse_phase,
        intermediate_phase_step, gain_out_of_range, coarse_delay_ps, pad_violation};

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // expected outputs from the bench copy of the words
    function automatic logic [40:0] snap(input logic err);
        int dl;
        dl = e_c[14:10] * 65 + e_c[9:7] * 11;
        return {err, e_g[15:7], e_f[15:8], e_c[15:7], e_g[15:7] < 9'h0c0 || e_g[15:7] > 9'h1c0, dl[11:0], e_pad};
    endfunction : snap

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic chk(input string name, input logic [40:0] seen, input logic [40:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task give_verdict;
        if (n_fail == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict

    // one apb transfer, expectation noted first
    task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] dt, input logic [3:0] s);
        int n;
        logic err;
        err = !w || s != 4'hf || !(a == A_G || a == A_F || a == A_C);
        if (!err) begin
            if (a == A_G) e_g = dt;
            if (a == A_F) e_f = dt;
            if (a == A_C) e_c = dt;
            if ((a == A_F) ? dt[7:0] != 8'hff : dt[6:0] != 7'h7f) e_pad = 1'b1;
        end
        exp_q.push_back(snap(err));
        upd_q.push_back(!err && a == A_G);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {seed[31:16], dt};
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            n_fail++;
            give_verdict;
        end
    endtask : apb

    // compare each answered transfer with the oldest note
    always @(posedge clk_sys) begin
        if (pready === 1'b1) begin
            chk("response", obs, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
            chk("gain update", {40'h0, gain_updated}, {40'h0, ((upd_q.size() > 0) ? upd_q.pop_front() : 1'bx)});
            chk("read data", {9'h0, prdata}, 41'h0);
            chk("mode flag", {40'h0, gain_trim_active}, {40'h0, extended_mode});
        end
    end

    initial begin
        sys_rst = 1'b1;
        extended_mode = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        seed = 32'd96569;
        n_fail = 0;
        total_checks = 0;
        e_g = agc_pkg::RST_Q_FULL_SCALE_TRIM;
        e_f = agc_pkg::RST_SAMPLE_PHASE_FINE;
        e_c = agc_pkg::RST_SAMPLE_PHASE_COARSE;
        e_pad = 1'b0;
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk("reset state", obs, snap(1'b0));
        chk("gain active", {40'h0, gain_trim_active}, 41'h1);
        // gain codes at the range ends and window edges
        foreach (gtab[i]) apb(1'b1, A_G, {gtab[i], 7'h7f}, 4'hf);
        // random words to all three places, pads kept at ones
        for (int i = 0; i < 30; i++) begin
            seed = lfsr(seed);
            extended_mode <= seed[20];
            ad = (seed[17:16] == 2'h0) ? A_G : (seed[17:16] == 2'h1) ? A_F : A_C;
            d = seed[15:0] | ((ad == A_F) ? 16'h00ff : 16'h007f);
            apb(1'b1, ad, d, 4'hf);
        end
        // refused: read, partial strobe, unmapped index
        apb(1'b0, A_G, 16'h0000, 4'hf);
        apb(1'b1, A_F, 16'h12ff, 4'h3);
        apb(1'b1, 12'h024, 16'hffff, 4'hf);
        // low pads not ones, then a clean write: flag stays
        apb(1'b1, A_C, 16'h8000, 4'hf);
        apb(1'b1, A_G, 16'h807f, 4'hf);
        apb(1'b1, A_C, 16'h047f, 4'hf);
        repeat (3) @(posedge clk_sys);
        chk("queue drained", {40'h0, exp_q.size() == 0}, 41'h1);
        give_verdict;
    end
endmodule : testbench
